// File: hw/nsd_exec.sv
// decode and execute unit for the nibble-swap and direction-load instructions
`timescale 1ns/100ps

// How it works
// - a nibble-swap result is the addressed file value with its two nibbles exchanged.
// - with the destination bit clear the swapped value goes to W and the file is untouched.
// - with the destination bit set the swapped value goes back to the file register read.
// - the direction-load word copies W into direction register five, six or seven.
// - ordinary register-file reads and writes also reach the three direction registers.
module nsd_exec
  import nsd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire nsd_instr_s instr_i,
  input wire nsd_rf_s rf_i,
  output logic w_we_o,
  output logic [DATA_W-1:0] w_wdata_o,
  output logic file_we_o,
  output logic [FADDR_W-1:0] file_waddr_o,
  output logic [DATA_W-1:0] file_wdata_o,
  output logic [DIR_NUM-1:0][DATA_W-1:0] dir_o,
  output logic [DATA_W-1:0] rf_rdata_o,
  output logic done_o,
  output logic unknown_o
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  nsd_state_s st_reg;
  nsd_state_s st_next;
  logic is_swap;
  logic is_dirld;
  logic dest_file;
  logic [DATA_W-1:0] swapped;
  logic [DIR_NUM-1:0] dl_hit;
  logic [DIR_NUM-1:0] rf_hit;

  // opcode match on the one instruction word
  assign is_swap = instr_i.valid && (instr_i.word[OPC_MSB:OPC_LSB] == OPC_NIBBLE_SWAP);
  // out-of-range selectors (0..4) are not a direction load at all
  assign is_dirld = instr_i.valid
    && (instr_i.word[OPC_MSB:DIRLD_LSB] == OPC_DIRECTION_LOAD)
    && (instr_i.word[SEL_MSB:0] >= DIR_SEL_FIRST);
  assign dest_file = instr_i.word[DEST_BIT];
  // plain rewiring, no adder, so it fits in the execute cycle
  // limitation: the file value comes in from the datapath, so swapping a direction
  // register through the file port sees the outer copy, not dir_o
  assign swapped = {instr_i.file_data[NIB_W-1:0], instr_i.file_data[DATA_W-1:NIB_W]};

  // ----------------------------------------------------------------
  // per direction register hit decode
  // ----------------------------------------------------------------
  generate
    for (genvar gi = 0; gi < DIR_NUM; gi++) begin : g_hit
      assign dl_hit[gi] = is_dirld
        && (instr_i.word[SEL_MSB:0] == 3'(DIR_SEL_FIRST + 3'(gi)));
      assign rf_hit[gi] = (rf_i.addr == 8'(DIR_FILE_BASE + 8'(gi)));
      // each register answers its own read, write and load one cycle later
      rf_read_each_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rf_hit[gi] |=> rf_rdata_o == $past(dir_o[gi]))
        else $error("direction register read returned the wrong value");
      rf_write_each_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rf_i.we && rf_hit[gi] && !dl_hit[gi] |=> dir_o[gi] == $past(rf_i.wdata))
        else $error("direction register write was lost");
      dl_each_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        dl_hit[gi] |=> dir_o[gi] == $past(instr_i.w_data))
        else $error("direction load missed its register");
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.w_we = 1'b0;
    st_next.f_we = 1'b0;
    st_next.done = 1'b0;
    st_next.unknown = 1'b0;
    st_next.rf_rdata = DATA_ZERO;
    // swap: route result by the destination bit
    if (is_swap) begin
      st_next.done = 1'b1;
      st_next.f_waddr = instr_i.word[FILE_MSB:0];
      if (dest_file) begin
        st_next.f_we = 1'b1;
        st_next.f_wdata = swapped;
      end else begin
        st_next.w_we = 1'b1;
        st_next.w_wdata = swapped;
      end
    end else if (is_dirld) begin
      st_next.done = 1'b1;
    end else if (instr_i.valid) begin
      st_next.unknown = 1'b1;
    end
    // ordinary access first, so a load in the same cycle wins
    for (int i = 0; i < DIR_NUM; i++) begin
      if (rf_hit[i]) begin
        st_next.rf_rdata = st_reg.dir[i];
        if (rf_i.we) begin
          st_next.dir[i] = rf_i.wdata;
        end
      end
      if (dl_hit[i]) begin
        st_next.dir[i] = instr_i.w_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg.w_we <= 1'b0;
      st_reg.w_wdata <= DATA_ZERO;
      st_reg.f_we <= 1'b0;
      st_reg.f_waddr <= FADDR_ZERO;
      st_reg.f_wdata <= DATA_ZERO;
      st_reg.dir <= {DIR_NUM{DIR_RESET}};
      st_reg.rf_rdata <= DATA_ZERO;
      st_reg.done <= 1'b0;
      st_reg.unknown <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops, the done and unknown flag ports included
  assign w_we_o = st_reg.w_we;
  assign w_wdata_o = st_reg.w_wdata;
  assign file_we_o = st_reg.f_we;
  assign file_waddr_o = st_reg.f_waddr;
  assign file_wdata_o = st_reg.f_wdata;
  assign dir_o = st_reg.dir;
  assign rf_rdata_o = st_reg.rf_rdata;
  assign done_o = st_reg.done;
  assign unknown_o = st_reg.unknown;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // all checks below sample on the core clock and rest while reset is high
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a swap word, whatever its destination bit
  sequence swap_issued_s;
    instr_i.valid && (instr_i.word[OPC_MSB:OPC_LSB] == OPC_NIBBLE_SWAP);
  endsequence

  // done follows one edge after the word, never later
  sequence one_cycle_done_s;
    ##1 done_o;
  endsequence

  swap_nibbles_a: assert property (
    swap_issued_s |=> ((w_we_o ? w_wdata_o : file_wdata_o)
      == {$past(instr_i.file_data[NIB_W-1:0]), $past(instr_i.file_data[DATA_W-1:NIB_W])}))
    else $error("swap result does not exchange the nibbles");

  swap_to_w_a: assert property (
    swap_issued_s and !instr_i.word[DEST_BIT] |=> w_we_o && !file_we_o)
    else $error("swap with clear destination did not go to W only");

  swap_to_file_a: assert property (
    swap_issued_s and instr_i.word[DEST_BIT] |=> file_we_o && !w_we_o
      && (file_waddr_o == $past(instr_i.word[FILE_MSB:0])))
    else $error("swap with set destination did not write back the file");

  dir_load_a: assert property (
    is_dirld |=> dir_o[$past(instr_i.word[SEL_MSB:0]) - DIR_SEL_FIRST]
      == $past(instr_i.w_data))
    else $error("direction load did not copy W");

  dir_load_limit_a: assert property (
    instr_i.valid && (instr_i.word[OPC_MSB:DIRLD_LSB] == OPC_DIRECTION_LOAD)
      && (instr_i.word[SEL_MSB:0] < DIR_SEL_FIRST) && !rf_i.we |=> $stable(dir_o))
    else $error("out-of-range direction load changed a register");

  rf_dir_read_a: assert property (
    (rf_i.addr == DIR_FILE_BASE) && !is_dirld |=> rf_rdata_o == $past(dir_o[0]))
    else $error("register-file read of a direction register wrong");

  rf_dir_write_a: assert property (
    rf_i.we && (rf_i.addr == 8'(DIR_FILE_BASE + 8'h02)) && !is_dirld
      |=> dir_o[2] == $past(rf_i.wdata))
    else $error("register-file write of a direction register lost");

  one_cycle_a: assert property (
    (is_swap || is_dirld) |-> one_cycle_done_s)
    else $error("instruction did not finish in one cycle");

  dirld_no_write_a: assert property (
    is_dirld |=> !w_we_o && !file_we_o)
    else $error("direction load disturbed W or the file");

  // refused words must raise only unknown, and idle words must leave every strobe low
  unknown_op_a: assert property (
    instr_i.valid && !is_swap && !is_dirld
      |=> unknown_o && !done_o && !w_we_o && !file_we_o)
    else $error("undecoded word was not flagged or caused a write");

  idle_quiet_a: assert property (
    !instr_i.valid |=> !done_o && !w_we_o && !file_we_o && !unknown_o)
    else $error("strobe raised without an instruction");

  // direction registers move only on a load or a register-file write
  dir_untouched_a: assert property (
    !is_dirld && !rf_i.we |=> $stable(dir_o))
    else $error("direction register changed without a write");

  rf_miss_zero_a: assert property (
    (rf_hit == '0) |=> rf_rdata_o == DATA_ZERO)
    else $error("read data not zero for a non-direction address");

endmodule : nsd_exec

// File: hw/nsd_pkg.sv
// shared constants and carrier types for the nibble-swap / direction-load unit
package nsd_pkg;

  // ----------------------------------------------------------------
  // instruction word layout
  // ----------------------------------------------------------------
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned RF_ADDR_W = 8;
  localparam int unsigned OPC_MSB = 13;
  localparam int unsigned OPC_LSB = 8;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned FILE_MSB = 6;
  localparam int unsigned DIRLD_LSB = 3;
  localparam int unsigned SEL_MSB = 2;
  localparam logic [5:0] OPC_NIBBLE_SWAP = 6'h0E;
  localparam logic [10:0] OPC_DIRECTION_LOAD = 11'h00C;

  // ----------------------------------------------------------------
  // direction registers
  // ----------------------------------------------------------------
  localparam int unsigned DIR_NUM = 3;
  localparam logic [2:0] DIR_SEL_FIRST = 3'h5;
  localparam logic [2:0] DIR_SEL_LAST = 3'h7;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] DIR_FILE_BASE = 8'h85;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [6:0] FADDR_ZERO = 7'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [INSTR_W-1:0] word;
    logic [DATA_W-1:0] file_data;
    logic [DATA_W-1:0] w_data;
  } nsd_instr_s;

  typedef struct packed {
    logic we;
    logic [RF_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } nsd_rf_s;

  typedef struct packed {
    logic w_we;
    logic [DATA_W-1:0] w_wdata;
    logic f_we;
    logic [FADDR_W-1:0] f_waddr;
    logic [DATA_W-1:0] f_wdata;
    logic [DIR_NUM-1:0][DATA_W-1:0] dir;
    logic [DATA_W-1:0] rf_rdata;
    logic done;
    logic unknown;
  } nsd_state_s;

endpackage : nsd_pkg

// File: test/nsd_exec_tb.sv
// self-checking bench for the nibble-swap / direction-load unit
`timescale 1ns/100ps
module nsd_exec_tb
  import nsd_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus, expectation notes and the unit
  // ----------------------------------------------------------------
  typedef struct {
    logic w_we; logic [7:0] w_d; logic f_we; logic [6:0] f_a; logic [7:0] f_d;
    logic [2:0][7:0] dir; logic [7:0] rd;
    logic done; logic unk; int due;
  } nsd_note_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  nsd_instr_s instr_i = '0;
  nsd_rf_s rf_i = '0;
  logic w_we_o, file_we_o, done_o, unknown_o;
  logic [7:0] w_wdata_o, file_wdata_o, rf_rdata_o;
  logic [6:0] file_waddr_o;
  logic [2:0][7:0] dir_o;
  logic [2:0][7:0] dm = {3{DIR_RESET}};
  // last data and address the unit must still be holding
  logic [7:0] wm = 8'h00;
  logic [7:0] fm = 8'h00;
  logic [6:0] am = 7'h00;
  nsd_note_s q[$];
  nsd_note_s mn;
  int n_fail = 0;
  int cmp_count = 0;
  int ncyc = 0;
  int seed = 10;
  logic [31:0] r;
  logic [7:0] k;
  nsd_exec i_dut (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i), .rf_i(rf_i),
    .w_we_o(w_we_o), .w_wdata_o(w_wdata_o), .file_we_o(file_we_o),
    .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o), .dir_o(dir_o),
    .rf_rdata_o(rf_rdata_o), .done_o(done_o), .unknown_o(unknown_o));
  always #5 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
    cmp_count++;
    if (e !== s) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // drive one cycle and note what the unit must show one cycle later
  task automatic step(input logic v, input logic [13:0] wd, input logic [7:0] fd,
                      input logic [7:0] wv, input logic we, input logic [7:0] a,
                      input logic [7:0] wdt);
    nsd_note_s n;
    logic [7:0] sw;
    @(posedge clk_i);
    instr_i <= '{v, wd, fd, wv};
    rf_i <= '{we, a, wdt};
    n = '{default: 0};
    n.dir = dm;
    n.w_d = wm; // data outputs hold until the next swap
    n.f_d = fm;
    n.f_a = am;
    n.due = ncyc + 2;
    sw = {fd[3:0], fd[7:4]};
    n.rd = (a >= 8'h85 && a <= 8'h87) ? dm[a - 8'h85] : 8'h00;
    if (we && a >= 8'h85 && a <= 8'h87) n.dir[a - 8'h85] = wdt;
    if (v && wd[13:8] == OPC_NIBBLE_SWAP) begin
      n.done = 1'b1;
      n.f_a = wd[6:0];
      if (wd[7]) begin
        n.f_we = 1'b1;
        n.f_d = sw;
      end else begin
        n.w_we = 1'b1;
        n.w_d = sw;
      end
    end else if (v && wd[13:3] == OPC_DIRECTION_LOAD && wd[2:0] >= 3'h5) begin
      n.done = 1'b1;
      n.dir[wd[2:0] - 3'h5] = wv; // instruction wins over a same-cycle write
    end else if (v) n.unk = 1'b1;
    dm = n.dir;
    wm = n.w_d;
    fm = n.f_d;
    am = n.f_a;
    q.push_back(n);
  endtask : step
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // monitor: oldest note against the outputs once it falls due
  // ----------------------------------------------------------------
  always @(negedge clk_i) begin
    ncyc++;
    if (q.size() > 0 && q[0].due <= ncyc) begin
      mn = q.pop_front();
      chk("w_we", mn.w_we, w_we_o);
      chk("file_we", mn.f_we, file_we_o);
      chk("w_wdata", mn.w_d, w_wdata_o);
      chk("file_wdata", mn.f_d, file_wdata_o);
      chk("file_waddr", mn.f_a, file_waddr_o);
      chk("dir", mn.dir, dir_o);
      chk("rf_rdata", mn.rd, rf_rdata_o);
      chk("done", mn.done, done_o);
      chk("unknown", mn.unk, unknown_o);
    end
  end
  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    step(0, 0, 0, 0, 0, 0, 0);
    step(1, 14'h0E05, 8'hA5, 0, 0, 0, 0);
    step(1, 14'h0E85, 8'h3C, 0, 0, 0, 0);
    step(1, 14'h0E7F, 8'h0F, 0, 0, 0, 0);
    step(1, 14'h0EFF, 8'hF0, 0, 0, 0, 0);
    $display("test swap done");
    for (int i = 0; i < 8; i++) step(1, 14'h0060 | i, 0, 8'h11 * i + 8'h0F, 0, 0, 0);
    step(1, 14'h0685, 0, 0, 0, 0, 0);
    $display("test direction load done");
    for (int i = 0; i < 5; i++) begin
      k = 8'h84 + i;
      step(0, 0, 0, 0, 1, k, 8'hC3 ^ k);
      step(0, 0, 0, 0, 0, k, 0);
    end
    step(1, 14'h0065, 0, 8'h77, 1, 8'h85, 8'h99);
    step(0, 0, 0, 0, 0, 8'h85, 0);
    $display("test register file done");
    // reset again mid-run: every output but rf_rdata must come back to its reset value; rf_rdata reads back direction register seven
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    dm = {3{DIR_RESET}};
    wm = 8'h00;
    fm = 8'h00;
    am = 7'h00;
    step(0, 0, 0, 0, 0, 8'h87, 0);
    $display("test mid-run reset done");
    repeat (300) begin
      r = $random(seed);
      case (r[5:4])
        2'd0: k = 8'h0E;
        2'd1: k = 8'h00;
        default: k = r[29:22];
      endcase
      step(r[5:4] != 2'd3, (r[5:4] == 2'd1) ? {11'h00C, r[10:8]} : {k[5:0], r[15:8]},
           $random(seed), $random(seed), r[0], 8'h83 + r[3:1], $random(seed));
    end
    step(0, 0, 0, 0, 0, 0, 0);
    repeat (3) @(posedge clk_i);
    $display("test random mix done");
    chk("pending", 24'h0, 24'(q.size()));
    finish_test();
  end
endmodule : nsd_exec_tb
